// file: testbench/adcst_conv_model.sv
// Purpose: converter stand-in answering each trigger
// Assumes: triggers at least 40 cycles apart
// Notes: code lines toggle while no result is offered
module adcst_conv_model (
	input wire logic ref_clk_i,
	input wire logic trig_i,
	input wire logic [15:0] code_i,
	output adcst_pkg::adcst_conv_t conv_o = '0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] cnt = 6'h00;
	always @(posedge ref_clk_i) begin
		cnt <= trig_i ? 6'h28 : cnt - {5'h00, cnt != 6'h00};
		conv_o.done <= cnt == 6'h01;
		conv_o.code <= cnt == 6'h01 ? code_i : ~conv_o.code;
	end
endmodule // adcst_conv_model

// file: testbench/adcst_scan_ctrl_sva.sv
// Purpose: port checks of the scan timing control
// Assumes: one clock, reset synchronous and active high
// Notes: format is only visible in bit 15, so lower bits are compared
module adcst_scan_ctrl_sva (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic acq_run_i,
	input wire adcst_pkg::adcst_conv_t conv_i,
	input wire logic conv_trigger_o,
	input wire adcst_pkg::adcst_result_t result_o,
	input wire logic irq_req_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	property p_unused; reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o[15:14] == 2'h0; endproperty
	a_unused: assert property (p_unused) else $error("unused bits set");
	property p_irq; irq_req_o |-> $past(conv_i.done); endproperty
	a_irq: assert property (p_irq) else $error("irq without done");
	property p_res; result_o.valid |-> $past(conv_i.done && acq_run_i); endproperty
	a_res: assert property (p_res) else $error("stray result");
	property p_fmt; result_o.valid |-> result_o.data[14:0] == $past(conv_i.code[14:0]); endproperty
	a_fmt: assert property (p_fmt) else $error("result bits wrong");
	property p_gap; conv_trigger_o |=> !conv_trigger_o [*8]; endproperty
	a_gap: assert property (p_gap) else $error("trigger too soon");
	property p_halt; !acq_run_i |=> !conv_trigger_o; endproperty
	a_halt: assert property (p_halt) else $error("trigger while halted");
	property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_rst; disable iff (1'b0) rst_i |=> reg_rdata_o == 32'h0 && !irq_req_o &&
		!result_o.valid && !conv_trigger_o; endproperty
	a_rst: assert property (p_rst) else $error("not cleared");
endmodule // adcst_scan_ctrl_sva
bind adcst_scan_ctrl adcst_scan_ctrl_sva u_sva (.ref_clk_i, .rst_i, .reg_addr_i, .reg_rd_i,
	.reg_rdata_o, .acq_run_i, .conv_i, .conv_trigger_o, .result_o, .irq_req_o);

// file: testbench/testbench.sv
// Purpose: self-checking bench of the scan timing control
// Assumes: converter model answers 40 cycles after a trigger
// Notes: divisors 64 and 1 give one result every 1600 cycles
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, acq_run_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [3:0] reg_be_i = 4'h0;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
	logic [15:0] code = 16'h0;
	logic [15:0] codes [4] = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000};
	// two's complement codes of the same four input levels
	logic [15:0] twos [4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};
	adcst_pkg::adcst_conv_t conv_i;
	adcst_pkg::adcst_result_t result_o;
	logic conv_trigger_o, irq_req_o;
	logic [4:0] chan_o;
	int num_errors = 0, tests_run = 0, nirq = 0, nval = 0;
	time t0;
	always #2.5 ref_clk_i = ~ref_clk_i;
	adcst_scan_ctrl u_dut (.ref_clk_i, .rst_i, .reg_addr_i, .reg_be_i, .reg_wr_i, .reg_rd_i,
		.reg_wdata_i, .reg_rdata_o, .acq_run_i, .conv_i, .conv_trigger_o, .chan_o, .result_o,
		.irq_req_o);
	adcst_conv_model u_conv (.ref_clk_i, .trig_i(conv_trigger_o), .code_i(code), .conv_o(conv_i));
	task automatic print_verdict();
		$display("errors %0d compares %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one access per call; for reads d is the expected word
	task automatic acc(logic w, logic [7:0] a, logic [3:0] be, logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_be_i <= be;
		reg_wdata_i <= d;
		reg_wr_i <= w;
		reg_rd_i <= !w;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		@(negedge ref_clk_i);
		if (!w) chk(reg_rdata_o, d);
	endtask
	always @(posedge ref_clk_i) begin
		if (irq_req_o === 1'b1) nirq++;
		if (result_o.valid === 1'b1) nval++;
	end
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		num_errors++;
		print_verdict();
	end
	initial begin
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		acc(0, 8'h08, 4'h3, 32'h0);
		acc(1, 8'h00, 4'h3, 32'hF001);
		acc(0, 8'h00, 4'h3, 32'h3001);
		acc(1, 8'h08, 4'h2, 32'h3F00);
		acc(0, 8'h08, 4'h3, 32'h3F00);
		acc(1, 8'h08, 4'hF, 32'h4000);
		acc(0, 8'h08, 4'hF, 32'h4000);
		acc(1, 8'h0C, 4'h3, 32'h1);
		acc(0, 8'h0C, 4'h3, 32'h1);
		acc(1, 8'h10, 4'h3, 32'h0302);
		acc(0, 8'h10, 4'h3, 32'h0302);
		for (int m = 0; m < 4; m++) begin
			@(posedge ref_clk_i);
			acq_run_i <= 1'b0;
			acc(1, 8'h00, 4'h3, (m << 12) | (m & 1));
			chk({27'h0, chan_o}, 32'h2);
			nirq = 0;
			@(posedge ref_clk_i);
			acq_run_i <= 1'b1;
			for (int k = 0; k < 4; k++) begin
				code <= codes[k];
				@(negedge ref_clk_i);
				// looked at mid-cycle, where the registered pulse has settled
				for (int n = 0; n < 2000 && result_o.valid !== 1'b1; n++) @(negedge ref_clk_i);
				if (k > 0) chk(32'($time - t0), 32'h1F40);
				t0 = $time;
				chk({16'h0, result_o.data}, m[0] ? codes[k] : twos[k]);
				chk({27'h0, result_o.chan}, 32'h2 + 32'(k % 2));
				@(posedge ref_clk_i);
			end
			repeat (3) @(posedge ref_clk_i);
			chk(nirq, m == 1 ? 32'h4 : m == 2 ? 32'h2 : 32'h0);
		end
		acc(1, 8'h08, 4'h2, 32'h3F00);
		nval = 0;
		repeat (4000) @(posedge ref_clk_i);
		chk(nval, 32'h0);
		print_verdict();
	end
endmodule // testbench

// file: verilog/adcst_divider.sv
// Purpose: reloading down counter, one pulse per terminal count
// Assumes: enable pulses are single cycles of ref_clk_i
// Notes: a divisor of zero stops the output
module adcst_divider #(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic en_i,
	input wire logic [WIDTH-1:0] divisor_i,
	output logic tc_o
);

	logic [WIDTH-1:0] count;
	logic at_end;

	assign at_end = (count <= {{(WIDTH-1){1'b0}}, 1'b1});

	// stopped counter preloads so the first period is a full one
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !run_i) begin
			count <= divisor_i;
		end else if (en_i) begin
			if (at_end) begin
				count <= divisor_i;
			end else begin
				count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !run_i) begin
			tc_o <= 1'b0;
		end else begin
			tc_o <= en_i && at_end && (divisor_i != '0);
		end
	end

endmodule // adcst_divider

// file: verilog/adcst_pkg.sv
// Purpose: shared types of the scan timing control
// Assumes: nothing beyond the header constants
// Notes: imported by no one, every use is scoped
package adcst_pkg;

	typedef enum logic [1:0] {
		ADCST_IRQ_OFF = 2'h0,
		ADCST_IRQ_EACH = 2'h1,
		ADCST_IRQ_GROUP = 2'h2,
		ADCST_IRQ_OFF2 = 2'h3
	} adcst_irq_mode_t;

	typedef struct packed {
		logic valid;
		logic [4:0] chan;
		logic [15:0] data;
	} adcst_result_t;

	typedef struct packed {
		logic done;
		logic [15:0] code;
	} adcst_conv_t;

endpackage

// file: verilog/adcst_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: byte addresses on the register port, word aligned
// Notes: definitions only
`ifndef ADCST_REGS_SVH
`define ADCST_REGS_SVH

`define ADCST_OFF_CONTROL 8'h00
`define ADCST_OFF_PRESCALE_WORD 8'h08
`define ADCST_OFF_PRESCALE 8'h09
`define ADCST_OFF_CONV_TIMER 8'h0C
`define ADCST_OFF_CHANNELS 8'h10

`define ADCST_CTRL_FORMAT_BIT 0
`define ADCST_CTRL_IRQ_LSB 12
`define ADCST_CTRL_IRQ_MSB 13
`define ADCST_CTRL_STORED_BITS 14
`define ADCST_CTRL_RESET 14'h0000
`define ADCST_PRESCALE_RESET 8'h00
`define ADCST_CONV_TIMER_RESET 16'h0000
`define ADCST_CHAN_RESET 5'h00

`define ADCST_PRESCALE_MIN 8'h40
`define ADCST_SIGN_FLIP 16'h8000

`define ADCST_REF_CLK_MHZ 200
`define ADCST_TIMEBASE_MHZ 8
`define ADCST_TIMEBASE_DIV (`ADCST_REF_CLK_MHZ / `ADCST_TIMEBASE_MHZ)

`endif

// file: verilog/adcst_scan_ctrl.sv
// Purpose: control and divider registers, trigger timing, result format, interrupts
// Assumes: converter reports each finished channel with a one-cycle done pulse
// Notes: raw converter code is straight binary; read data answers one cycle later
`include "adcst_regs.svh"

// Notes on behaviour
// - modes 00 and 11 give no interrupt
// - mode 01 interrupts after every channel
// - mode 10 interrupts once per finished group
// - group spans first through last channel inclusive
// - control bits 14, 15 read zero
// - control bit 0 picks result format
// - two's complement codes, midscale 0000
// - straight binary codes, midscale 8000
// - 8-bit first divider at 09H, 8 MHz
// - first divider feeds second, makes triggers
// - first divider below 64 blocks results
// - first divider takes 32/16/8-bit access
// - first divider clears on reset
// - period equals first times second over eight
// - halting returns pointer to first channel
module adcst_scan_ctrl (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [3:0] reg_be_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	input wire logic acq_run_i,
	input wire adcst_pkg::adcst_conv_t conv_i,
	output logic conv_trigger_o,
	output logic [4:0] chan_o,
	output adcst_pkg::adcst_result_t result_o,
	output logic irq_req_o
);

	logic [`ADCST_CTRL_STORED_BITS-1:0] acquisition_control;
	logic [7:0] first_stage_divider;
	logic [15:0] second_stage_divider;
	logic [4:0] first_chan;
	logic [4:0] last_chan;
	logic [4:0] next_chan;
	logic [4:0] tb_count;
	logic tb_tick;
	logic first_tc;
	logic second_tc;
	logic wr_ctrl;
	logic wr_presc;
	logic wr_timer;
	logic wr_chan;
	logic group_end;
	logic results_ok;
	logic [15:0] fmt_code;
	logic [31:0] next_rdata;
	adcst_pkg::adcst_irq_mode_t irq_mode;

	// byte enables decide which bytes of the addressed word a write touches
	assign wr_ctrl = reg_wr_i && (reg_addr_i == `ADCST_OFF_CONTROL);
	assign wr_presc = reg_wr_i && (reg_addr_i == `ADCST_OFF_PRESCALE_WORD);
	assign wr_timer = reg_wr_i && (reg_addr_i == `ADCST_OFF_CONV_TIMER);
	assign wr_chan = reg_wr_i && (reg_addr_i == `ADCST_OFF_CHANNELS);
	assign irq_mode = adcst_pkg::adcst_irq_mode_t'(
		acquisition_control[`ADCST_CTRL_IRQ_MSB:`ADCST_CTRL_IRQ_LSB]);

	// bits 15:14 are never stored, so they cannot read back
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			acquisition_control <= `ADCST_CTRL_RESET;
		end else if (wr_ctrl) begin
			if (reg_be_i[0]) begin
				acquisition_control[7:0] <= reg_wdata_i[7:0];
			end
			if (reg_be_i[1]) begin
				acquisition_control[13:8] <= reg_wdata_i[13:8];
			end
		end
	end

	// divider byte sits in lane 1 of its word, so any access width reaches it
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			first_stage_divider <= `ADCST_PRESCALE_RESET;
		end else if (wr_presc && reg_be_i[1]) begin
			first_stage_divider <= reg_wdata_i[15:8];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			second_stage_divider <= `ADCST_CONV_TIMER_RESET;
		end else if (wr_timer) begin
			if (reg_be_i[0]) begin
				second_stage_divider[7:0] <= reg_wdata_i[7:0];
			end
			if (reg_be_i[1]) begin
				second_stage_divider[15:8] <= reg_wdata_i[15:8];
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			first_chan <= `ADCST_CHAN_RESET;
			last_chan <= `ADCST_CHAN_RESET;
		end else if (wr_chan) begin
			if (reg_be_i[0]) begin
				first_chan <= reg_wdata_i[4:0];
			end
			if (reg_be_i[1]) begin
				last_chan <= reg_wdata_i[12:8];
			end
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (reg_addr_i)
			`ADCST_OFF_CONTROL: next_rdata[13:0] = acquisition_control;
			`ADCST_OFF_PRESCALE_WORD: next_rdata[15:8] = first_stage_divider;
			`ADCST_OFF_CONV_TIMER: next_rdata[15:0] = second_stage_divider;
			`ADCST_OFF_CHANNELS: next_rdata[15:0] = {3'h0, last_chan, 3'h0, first_chan};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end
	end

	// 8 MHz timebase taken from the reference clock as a one-cycle tick
	assign tb_tick = (tb_count == 5'(`ADCST_TIMEBASE_DIV - 1));

	always_ff @(posedge ref_clk_i) begin
		// cleared while halted, so a start always waits one full tick
		if (rst_i || !acq_run_i || tb_tick) begin
			tb_count <= 5'h00;
		end else begin
			tb_count <= tb_count + 5'h01;
		end
	end

	// period = first * second timebase ticks, i.e. first * second / 8 us
	adcst_divider #(.WIDTH(8)) u_first_stage (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.run_i(acq_run_i),
		.en_i(tb_tick),
		.divisor_i(first_stage_divider),
		.tc_o(first_tc)
	);

	adcst_divider #(.WIDTH(16)) u_second_stage (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.run_i(acq_run_i),
		.en_i(first_tc),
		.divisor_i(second_stage_divider),
		.tc_o(second_tc)
	);

	assign conv_trigger_o = second_tc;

	// the host must keep the divider at 64 or more; below that no result is flagged valid
	assign results_ok = (first_stage_divider >= `ADCST_PRESCALE_MIN);

	// a group whose last channel is below its first wraps through channel 31
	assign group_end = (chan_o == last_chan);

	always_comb begin
		next_chan = chan_o;
		if (conv_i.done) begin
			next_chan = group_end ? first_chan : chan_o + 5'h01;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			chan_o <= `ADCST_CHAN_RESET;
		end else if (!acq_run_i) begin
			// reload on every halted cycle so a restart begins at the first channel
			chan_o <= first_chan;
		end else begin
			chan_o <= next_chan;
		end
	end

	assign fmt_code = acquisition_control[`ADCST_CTRL_FORMAT_BIT] ?
		conv_i.code :
		(conv_i.code ^ `ADCST_SIGN_FLIP);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			result_o <= '0;
		end else begin
			// data and channel hold until the next done; only the valid pulse is gated
			result_o.valid <= conv_i.done && acq_run_i && results_ok;
			if (conv_i.done) begin
				result_o.chan <= chan_o;
				result_o.data <= fmt_code;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			irq_req_o <= 1'b0;
		end else begin
			// both off codes drop the request; a request is a one-cycle pulse
			unique case (irq_mode)
				adcst_pkg::ADCST_IRQ_EACH: irq_req_o <= conv_i.done && acq_run_i;
				adcst_pkg::ADCST_IRQ_GROUP: irq_req_o <= conv_i.done && acq_run_i && group_end;
				adcst_pkg::ADCST_IRQ_OFF, adcst_pkg::ADCST_IRQ_OFF2: irq_req_o <= 1'b0;
			endcase
		end
	end

endmodule // adcst_scan_ctrl
